// >>> hdl/motor_overload_protection.sv
// motor overload protection: thermal load estimate, foldback limit, warning, clamp
`timescale 1ns/1ps
`default_nettype none
`include "motor_overload_cfg.svh"

module motor_overload_protection
    import motor_overload_pkg::*;
#(
    parameter int unsigned DWELL_CYC = `DWELL_MS * `CLK_KHZ,
    parameter int unsigned FOLD_STEP_CYC = (`TAU_MS * `CLK_KHZ) >> `TAU_SHIFT,
    parameter int unsigned HEAT_STEP_CYC = `HEAT_STEP_MS * `CLK_KHZ
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire current_in_t cur_in,
    input wire par_req_t par_req,
    output logic [31:0] par_rdata_r,
    output logic par_ack_r,
    output logic [31:0] effective_limit_r,
    output logic [31:0] command_clamped_r,
    output logic load_warning_flag_r,
    output logic thermal_fold_active_r
);

    // ============================================================
    // helpers
    function automatic logic [31:0] min32(input logic [31:0] a, input logic [31:0] b);
        min32 = (a < b) ? a : b;
    endfunction

    // exponential step: a fraction of the gap, never zero so the target is reached
    function automatic logic [31:0] gap_step(input logic [31:0] gap);
        logic [31:0] s;
        s = gap >> `TAU_SHIFT;
        gap_step = (s == 32'h0) ? 32'h1 : s;
    endfunction

    logic overload;
    logic underload;
    logic [31:0] ceiling;
    logic fold_tick;
    logic heat_tick;

    assign overload = cur_in.actual > cur_in.continuous;
    assign underload = cur_in.actual < cur_in.continuous;
    // limitation: peak current must stay at or below 3435973836 mA for the ceiling to fit
    assign ceiling = cur_in.peak + (cur_in.peak >> `CEIL_SHIFT);

    // ============================================================
    // tick sources
    tick_divider #(
        .PERIOD(FOLD_STEP_CYC)
    ) u_fold_tick (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(1'b1),
        .tick_r(fold_tick)
    );

    tick_divider #(
        .PERIOD(HEAT_STEP_CYC)
    ) u_heat_tick (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(1'b1),
        .tick_r(heat_tick)
    );

    // ============================================================
    // parameter registers
    logic [7:0] thresh_r;
    logic [7:0] thresh_nxt;
    method_t method_r;
    method_t method_nxt;
    logic [31:0] rdata_nxt;
    logic ack_nxt;
    logic [15:0] pct_r;
    logic [31:0] fold_r;

    always_comb begin
        thresh_nxt = thresh_r;
        method_nxt = method_r;
        rdata_nxt = par_rdata_r;
        ack_nxt = 1'b0;
        if (par_req.wr) begin
            ack_nxt = 1'b1;
            case (par_req.addr)
                `OFS_LOAD_WARNING_THRESHOLD: begin
                    // out-of-range values saturate rather than wrap
                    if (par_req.wdata[7:0] > `THRESH_MAX || par_req.wdata[31:8] != 24'h0) begin
                        thresh_nxt = `THRESH_MAX;
                    end else begin
                        thresh_nxt = par_req.wdata[7:0];
                    end
                end
                `OFS_PROTECTION_METHOD_SELECT: begin
                    method_nxt = method_t'(par_req.wdata[0]);
                end
                default: begin
                    // read-only and unmapped writes are dropped
                end
            endcase
        end else if (par_req.rd) begin
            ack_nxt = 1'b1;
            case (par_req.addr)
                `OFS_FOLDBACK_CURRENT_OUT: rdata_nxt = fold_r;
                `OFS_THERMAL_LOAD_PERCENT: rdata_nxt = {16'h0, pct_r};
                `OFS_LOAD_WARNING_THRESHOLD: rdata_nxt = {24'h0, thresh_r};
                `OFS_PROTECTION_METHOD_SELECT: rdata_nxt = {31'h0, method_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            thresh_r <= `THRESH_RST;
            method_r <= method_t'(`METHOD_RST);
            par_rdata_r <= 32'h0;
            par_ack_r <= 1'b0;
        end else if (ce) begin
            thresh_r <= thresh_nxt;
            method_r <= method_nxt;
            par_rdata_r <= rdata_nxt;
            par_ack_r <= ack_nxt;
        end
    end

    // ============================================================
    // thermal load estimate and warning
    logic [15:0] pct_nxt;
    logic tfold_nxt;
    logic warn_nxt;

    always_comb begin
        pct_nxt = pct_r;
        if (heat_tick) begin
            if (overload && pct_r < `PCT_FULL) begin
                pct_nxt = pct_r + 16'h1;
            end else if (underload && pct_r > `PCT_MIN) begin
                pct_nxt = pct_r - 16'h1;
            end
        end
        tfold_nxt = thermal_fold_active_r;
        if (pct_r >= `PCT_FULL) begin
            tfold_nxt = 1'b1;
        end else if (pct_r < `PCT_RESTORE) begin
            tfold_nxt = 1'b0;
        end
        // equal to the threshold keeps the present state
        warn_nxt = load_warning_flag_r;
        if (pct_r > {8'h0, thresh_r}) begin
            warn_nxt = 1'b1;
        end else if (pct_r < {8'h0, thresh_r}) begin
            warn_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pct_r <= `PCT_MIN;
            thermal_fold_active_r <= 1'b0;
            load_warning_flag_r <= 1'b0;
        end else if (ce) begin
            pct_r <= pct_nxt;
            thermal_fold_active_r <= tfold_nxt;
            load_warning_flag_r <= warn_nxt;
        end
    end

    // ============================================================
    // foldback sequencer
    fold_state_t fst_r;
    fold_state_t fst_nxt;
    logic [31:0] fold_nxt;
    logic [31:0] dwell_r;
    logic [31:0] dwell_nxt;

    always_comb begin
        fst_nxt = fst_r;
        fold_nxt = fold_r;
        dwell_nxt = dwell_r;
        case (fst_r)
            fb_recover: begin
                dwell_nxt = 32'h0;
                if (fold_r > ceiling) begin
                    fold_nxt = ceiling;
                end else if (overload) begin
                    fst_nxt = fb_dwell;
                end else if (underload && fold_tick) begin
                    fold_nxt = min32(fold_r + gap_step(ceiling - fold_r), ceiling);
                end
            end
            fb_dwell: begin
                // output held unreduced until the dwell time has run out
                if (!overload) begin
                    fst_nxt = fb_recover;
                end else if (dwell_r >= DWELL_CYC - 1) begin
                    fst_nxt = fb_decline;
                end else begin
                    dwell_nxt = dwell_r + 32'h1;
                end
            end
            fb_decline: begin
                if (!overload) begin
                    fst_nxt = fb_recover;
                end else if (fold_tick && fold_r > cur_in.continuous) begin
                    fold_nxt = fold_r - gap_step(fold_r - cur_in.continuous);
                end else if (fold_r < cur_in.continuous) begin
                    fold_nxt = cur_in.continuous;
                end
            end
            default: begin
                fst_nxt = fb_recover;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fst_r <= fb_recover;
            // all ones: pulled down to the ceiling in the first enabled cycle
            fold_r <= 32'hffffffff;
            dwell_r <= 32'h0;
        end else if (ce) begin
            fst_r <= fst_nxt;
            fold_r <= fold_nxt;
            dwell_r <= dwell_nxt;
        end
    end

    // ============================================================
    // effective limit and command clamp
    logic [31:0] mech_limit;
    logic [31:0] limit_nxt;
    logic [31:0] cmd_nxt;

    always_comb begin
        if (method_r == method_thermal) begin
            mech_limit = thermal_fold_active_r ? cur_in.continuous : cur_in.peak;
        end else begin
            mech_limit = fold_r;
        end
        limit_nxt = min32(min32(cur_in.user_clamp, cur_in.peak), mech_limit);
        // one cycle of latency: the clamp uses the limit computed the cycle before
        cmd_nxt = min32(cur_in.command, effective_limit_r);
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            effective_limit_r <= 32'h0;
            command_clamped_r <= 32'h0;
        end else if (ce) begin
            effective_limit_r <= limit_nxt;
            command_clamped_r <= cmd_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/motor_overload_cfg.svh
// offsets, field widths, reset values and timing counts of the overload protection
`ifndef MOTOR_OVERLOAD_CFG_SVH
`define MOTOR_OVERLOAD_CFG_SVH

// ============================================================
// parameter offsets
`define OFS_FOLDBACK_CURRENT_OUT 12'h1d6
`define OFS_THERMAL_LOAD_PERCENT 12'h4a0
`define OFS_LOAD_WARNING_THRESHOLD 12'h684
`define OFS_PROTECTION_METHOD_SELECT 12'h686

// ============================================================
// field widths and reset values
`define PAR_ADDR_W 12
`define PAR_DATA_W 32
`define PCT_W 16
`define THRESH_W 8
`define THRESH_RST 8'h50
`define METHOD_RST 1'h0

// ============================================================
// load levels in percent
`define PCT_MIN 16'h0000
`define PCT_FULL 16'h0064
`define PCT_RESTORE 16'h005f
`define THRESH_MAX 8'h64

// ============================================================
// timing
`define CLK_KHZ 100000
`define DWELL_MS 10000
`define TAU_MS 10000
`define TAU_SHIFT 4
`define CEIL_SHIFT 2
`define HEAT_STEP_MS 100

`endif

// >>> hdl/motor_overload_pkg.sv
// types shared by the overload protection files
`default_nettype none

package motor_overload_pkg;

    // ============================================================
    // protection method
    typedef enum logic [0:0] {
        method_foldback = 1'b0,
        method_thermal = 1'b1
    } method_t;

    // ============================================================
    // foldback sequencer
    typedef enum logic [1:0] {
        fb_recover = 2'b00,
        fb_dwell = 2'b01,
        fb_decline = 2'b10
    } fold_state_t;

    // ============================================================
    // current-side inputs, all unsigned in milliamperes
    typedef struct packed {
        logic [31:0] actual;
        logic [31:0] continuous;
        logic [31:0] peak;
        logic [31:0] user_clamp;
        logic [31:0] command;
    } current_in_t;

    // ============================================================
    // parameter access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } par_req_t;

endpackage

`default_nettype wire

// >>> hdl/tick_divider.sv
// periodic one-cycle tick generator, restarted while run is low
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
    parameter int unsigned PERIOD = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic run,
    output logic tick_r
);

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_nxt;

    // ============================================================
    // counting
    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!run) begin
            cnt_nxt = 32'h0;
        end else if (cnt_r >= PERIOD - 1) begin
            cnt_nxt = 32'h0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> verification/motor_overload_sva.sv
// checker for the overload protection top module
`timescale 1ns/1ps
`default_nettype none

module motor_overload_sva
    import motor_overload_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire current_in_t cur_in,
    input wire par_req_t par_req,
    input wire logic [31:0] par_rdata_r,
    input wire logic par_ack_r,
    input wire logic [31:0] effective_limit_r,
    input wire logic [31:0] command_clamped_r,
    input wire logic load_warning_flag_r,
    input wire logic thermal_fold_active_r
);
    // ============================================================
    // shadows of method and threshold, tracked from writes
    logic mth_r;
    logic mth_nxt;
    logic [7:0] thr_r;
    logic [7:0] thr_nxt;

    function automatic logic [31:0] mn(input logic [31:0] a, input logic [31:0] b);
        return (a < b) ? a : b;
    endfunction

    always_comb begin
        mth_nxt = mth_r;
        thr_nxt = thr_r;
        if (ce && par_req.wr && par_req.addr == 12'h686) begin
            mth_nxt = par_req.wdata[0];
        end
        if (ce && par_req.wr && par_req.addr == 12'h684) begin
            thr_nxt = (par_req.wdata > 32'h64) ? 8'h64 : par_req.wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mth_r <= 1'b0;
            thr_r <= 8'h50;
        end else begin
            mth_r <= mth_nxt;
            thr_r <= thr_nxt;
        end
    end

    // ============================================================
    // assertions; $past forms keep the check correct if ce pauses
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    ack_latency_a: assert property ($past(ce && (par_req.rd || par_req.wr)) |-> par_ack_r)
        else $error("ack missing after access");
    ack_spurious_a: assert property ($past(ce && !par_req.rd && !par_req.wr) |-> !par_ack_r)
        else $error("ack without access");
    load_range_a: assert property (ce && par_req.rd && !par_req.wr
        && par_req.addr == 12'h4a0 |=> par_rdata_r <= 32'h64)
        else $error("load read above full");
    thresh_range_a: assert property (ce && par_req.rd && !par_req.wr
        && par_req.addr == 12'h684 |=> par_rdata_r <= 32'h64)
        else $error("threshold read above full");
    thermal_limit_a: assert property ($past(ce && mth_r && thermal_fold_active_r)
        |-> effective_limit_r <= $past(cur_in.continuous)) else $error("thermal limit not folded");
    fold_hold_a: assert property ($rose(thermal_fold_active_r)
        |-> thermal_fold_active_r[*8]) else $error("thermal fold released too soon");
    warn_at_full_a: assert property ($rose(thermal_fold_active_r) && $past(thr_r) < 8'h64
        |-> load_warning_flag_r) else $error("warning low at full load");
    limit_caps_a: assert property ($past(ce) |->
        effective_limit_r <= $past(cur_in.user_clamp) && effective_limit_r <= $past(cur_in.peak))
        else $error("limit above clamp or peak");
    cmd_clamp_a: assert property ($past(ce) |-> command_clamped_r ==
        mn($past(cur_in.command), $past(effective_limit_r))) else $error("command not clamped");
    // limit is still zero on the first edge after reset, so that edge is skipped
    fold_floor_a: assert property ($past(ce && !mth_r && !sys_rst) |->
        effective_limit_r >= mn(mn($past(cur_in.user_clamp), $past(cur_in.peak)),
        $past(cur_in.continuous))) else $error("foldback limit below continuous");

    cover property ($rose(thermal_fold_active_r));
    cover property ($fell(thermal_fold_active_r));
    cover property ($rose(load_warning_flag_r));
endmodule

bind motor_overload_protection motor_overload_sva i_motor_overload_sva (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .ce(ce), .cur_in(cur_in), .par_req(par_req), .par_rdata_r(par_rdata_r),
    .par_ack_r(par_ack_r), .effective_limit_r(effective_limit_r),
    .command_clamped_r(command_clamped_r), .load_warning_flag_r(load_warning_flag_r),
    .thermal_fold_active_r(thermal_fold_active_r));

`default_nettype wire

// >>> verification/current_loop_model.sv
// current regulator and measurement: actual current follows the clamped command
`timescale 1ns/1ps
`default_nettype none

module current_loop_model
    import motor_overload_pkg::*;
#(
    parameter logic [31:0] CONT = 32'h3e8,
    parameter logic [31:0] PEAK = 32'hbb8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [31:0] cmd,
    input wire logic [31:0] clamp,
    input wire logic [31:0] command_clamped_r,
    output var current_in_t cur_in
);
    // ============================================================
    // one-cycle regulator lag; no overshoot modelled
    logic [31:0] actual_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            actual_r <= 32'h0;
        end else begin
            actual_r <= command_clamped_r;
        end
    end

    always_comb begin
        cur_in = '{actual: actual_r, continuous: CONT, peak: PEAK, user_clamp: clamp, command: cmd};
    end
endmodule

`default_nettype wire

// >>> verification/testbench.sv
// overload protection testbench: registers, clamps, foldback and thermal load
`timescale 1ns/1ps
`default_nettype none

module testbench
    import motor_overload_pkg::*;
();
    // ============================================================
    // stimulus and design
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic [31:0] cmd = 32'h0;
    logic [31:0] clamp = 32'h0;
    par_req_t par_req = '0;
    current_in_t cur_in;
    logic [31:0] par_rdata_r, effective_limit_r, command_clamped_r, rdat;
    logic par_ack_r, load_warning_flag_r, thermal_fold_active_r;
    int errors = 0;
    int checks = 0;
    int cyc = 0;

    always #5 clk_sys = ~clk_sys;

    // short counts keep the run small: dwell 20, fold tick 4, heat tick 3
    motor_overload_protection #(.DWELL_CYC(20), .FOLD_STEP_CYC(4), .HEAT_STEP_CYC(3))
        i_motor_overload_protection (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
        .cur_in(cur_in), .par_req(par_req), .par_rdata_r(par_rdata_r), .par_ack_r(par_ack_r),
        .effective_limit_r(effective_limit_r), .command_clamped_r(command_clamped_r),
        .load_warning_flag_r(load_warning_flag_r), .thermal_fold_active_r(thermal_fold_active_r));
    current_loop_model i_current_loop_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd(cmd),
        .clamp(clamp), .command_clamped_r(command_clamped_r), .cur_in(cur_in));

    // ============================================================
    // shared tasks
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic setc(input logic [31:0] c, input logic [31:0] l);
        @(posedge clk_sys);
        cmd <= c;
        clamp <= l;
    endtask
    // rd and wr are one-cycle pulses, answered one cycle later
    task automatic par(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        par_req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk_sys);
        par_req <= '0;
        #1;
        chk_bit("ack", 1'b1, par_ack_r);
        rdat = par_rdata_r;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        par(1'b0, a, 32'h0);
        chk_val(nm, e, rdat);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        cmd <= 32'h0;
        clamp <= 32'h1388;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cyc_n(2);
    endtask
    task automatic wait_fold();
        int n = 0;
        while (thermal_fold_active_r !== 1'b1 && n < 400) begin
            cyc_n(1);
            n++;
        end
    endtask

    // ============================================================
    // scenarios
    task automatic t_regs();
        do_reset();
        rchk(12'h686, 32'h0, "method");
        rchk(12'h684, 32'h50, "thresh");
        par(1'b1, 12'h4a0, 32'hff);
        rchk(12'h4a0, 32'h0, "load");
        par(1'b1, 12'h684, 32'hc8);
        rchk(12'h684, 32'h64, "thresh_sat");
        par(1'b1, 12'h686, 32'h3);
        rchk(12'h686, 32'h1, "method_set");
        par(1'b1, 12'h1d6, 32'h0);
        rchk(12'h1d6, 32'hea6, "fold_ro");
        rchk(12'h100, 32'h0, "unmapped");
        $display("done t_regs");
    endtask
    task automatic t_clamp();
        do_reset();
        setc(32'h9c4, 32'h7d0);
        cyc_n(4);
        chk_val("limit", 32'h7d0, effective_limit_r);
        chk_val("cmd", 32'h7d0, command_clamped_r);
        // enable low: a new clamp must not reach the limit
        @(posedge clk_sys);
        ce <= 1'b0;
        clamp <= 32'h3e8;
        cyc_n(4);
        chk_val("limit_frozen", 32'h7d0, effective_limit_r);
        @(posedge clk_sys);
        ce <= 1'b1;
        setc(32'hfa0, 32'h1388);
        cyc_n(4);
        chk_val("cmd_peak", 32'hbb8, command_clamped_r);
        $display("done t_clamp");
    endtask
    task automatic t_fold();
        do_reset();
        setc(32'hbb8, 32'h1388);
        cyc_n(10);
        rchk(12'h1d6, 32'hea6, "fold_dwell");
        wait_fold();
        chk_bit("lim_ignores_load", 1'b1, effective_limit_r > 32'h3e8);
        cyc_n(500);
        rchk(12'h1d6, 32'h3e8, "fold_low");
        chk_val("limit_low", 32'h3e8, effective_limit_r);
        setc(32'h0, 32'h1388);
        cyc_n(800);
        rchk(12'h1d6, 32'hea6, "fold_ceil");
        chk_val("limit_peak", 32'hbb8, effective_limit_r);
        $display("done t_fold");
    endtask
    task automatic t_therm();
        int n = 0;
        do_reset();
        par(1'b1, 12'h686, 32'h1);
        par(1'b1, 12'h684, 32'h3c);
        setc(32'hbb8, 32'h1388);
        cyc_n(150);
        chk_val("limit_mode1", 32'hbb8, effective_limit_r);
        chk_bit("warn_low", 1'b0, load_warning_flag_r);
        wait_fold();
        cyc_n(2);
        chk_val("limit_thermal", 32'h3e8, effective_limit_r);
        chk_bit("warn_set", 1'b1, load_warning_flag_r);
        rchk(12'h4a0, 32'h64, "load_full");
        setc(32'h0, 32'h1388);
        rdat = 32'h64;
        while (rdat !== 32'h5f && n < 200) begin
            par(1'b0, 12'h4a0, 32'h0);
            n++;
        end
        chk_bit("fold_at_95", 1'b1, thermal_fold_active_r);
        cyc_n(8);
        chk_bit("fold_clear", 1'b0, thermal_fold_active_r);
        chk_val("limit_back", 32'hbb8, effective_limit_r);
        cyc_n(130);
        chk_bit("warn_clear", 1'b0, load_warning_flag_r);
        $display("done t_therm");
    endtask

    // ============================================================
    // run and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        t_regs();
        t_clamp();
        t_fold();
        t_therm();
        end_sim();
    end
endmodule

`default_nettype wire
